// ---- verilog/rule_engine_regs.svh ----
/*
 * Constants of the condition-logic rule engine: sizes, source map, timing counts.
 * Assumes the clock runs at 125 MHz and is included by its bare name.
 */
// Function
// [RULE1] Sixteen rules, each enabled or disabled on its own.
// [RULE2] Scan runs condition phase, then execution phase, then output phase, each in rule order.
// [RULE3] Results take effect only in the output phase; readers see them next scan.
// [RULE4] A flag written by one rule carries its result into another rule's conditions.
// [RULE5] One scan lasts about 600 us plus 370 us per enabled rule.
// [RULE6] One rule with a local output reacts within one millisecond.
// [RULE7] Output on a second module over one switch reacts within three milliseconds.
// [RULE8] At most three input conditions per rule, combined by the chosen operator.
// [RULE9] Chain option feeds a rule's result into the logic of the next rule.
// [RULE10] Direct chaining links only numerically adjacent rules.
// [RULE11] Flag links have no adjacency limit and may come from another module.
// [RULE12] A condition expecting False inverts its input before the operator.
// [RULE13] Each rule has an execution period setting how often it fires.
// [RULE14] A started timer accumulates time; other rules compare it to an interval.
// [RULE15] A rule reading its own output flag sees last execution's value.
// [RULE16] Timer action either starts counting, or stops and clears to zero.
// [RULE17] Counter action adds one or clears when satisfied, else does nothing.
// [RULE18] Flags false, timers and counters zero when the project starts running.
// [RULE19] Disabled rules are skipped and change no output, flag, timer or counter.
`ifndef RULE_ENGINE_REGS_SVH
`define RULE_ENGINE_REGS_SVH

`define LRE_NUM_RULES      16
`define LRE_NUM_COND       3
`define LRE_SEL_W          6
// source map offsets within the condition source vector
`define LRE_SRC_DI         0
`define LRE_SRC_FLAG       16
`define LRE_SRC_TIMER      32
`define LRE_SRC_COUNTER    36
`define LRE_SRC_EXT_FLAG   40
// timing
`define LRE_CLK_PERIOD_NS  8
`define LRE_BASE_US        600
`define LRE_PER_RULE_US    370
`define LRE_TICK_US        1
`define LRE_LOCAL_MAX_MS   1
`define LRE_REMOTE_MAX_MS  3

`endif

// ---- verilog/rule_engine_pkg.sv ----
/*
 * Types of the condition-logic rule engine.
 * Assumes rule_engine_regs.svh supplies the numeric constants.
 */
package rule_engine_pkg;

	typedef enum logic [4:0] {
		PH_IDLE = 5'b0_0001,
		PH_COND = 5'b0_0010,
		PH_EXEC = 5'b0_0100,
		PH_OUT  = 5'b0_1000,
		PH_WAIT = 5'b1_0000
	} phase_t;

	typedef enum logic [1:0] {
		OP_AND  = 2'h0,
		OP_OR   = 2'h1,
		OP_NAND = 2'h2,
		OP_NOR  = 2'h3
	} logic_op_t;

	typedef enum logic [1:0] {
		ACT_DO      = 2'h0,
		ACT_FLAG    = 2'h1,
		ACT_TIMER   = 2'h2,
		ACT_COUNTER = 2'h3
	} action_kind_t;

endpackage

// ---- verilog/logic_rule_engine.sv ----
/*
 * Condition-logic rule engine: a sequencer scans sixteen rules through condition,
 * execution and output phases, drives digital outputs, flags, timers and counters.
 * Assumes configuration ports are static while run is high and inputs are synchronous.
 */
`timescale 1ns/1ps
`include "rule_engine_regs.svh"

module logic_rule_engine #(
	parameter int          NR            = `LRE_NUM_RULES,
	parameter int          TMR_W         = 16,
	parameter int          CNT_W         = 16,
	parameter int          PRD_W         = 8,
	parameter logic [23:0] BASE_CYCLES   = 24'(`LRE_BASE_US * 1000 / `LRE_CLK_PERIOD_NS),
	parameter logic [23:0] PER_CYCLES    = 24'(`LRE_PER_RULE_US * 1000 / `LRE_CLK_PERIOD_NS),
	parameter int          TICK_CYCLES   = `LRE_TICK_US * 1000 / `LRE_CLK_PERIOD_NS
) (
	// clock and reset
	input  wire logic                    clock,
	input  wire logic                    arst_n,
	// project control
	input  wire logic                    run,
	// field and linked inputs
	input  wire logic [15:0]             di,
	input  wire logic [15:0]             ext_flag_in,
	// rule configuration
	input  wire logic [NR-1:0]           rule_enable,
	input  wire logic [NR*3*6-1:0]       cond_sel,
	input  wire logic [NR*3-1:0]         cond_used,
	input  wire logic [NR*3-1:0]         cond_expect_false,
	input  wire logic [NR*2-1:0]         rule_op,
	input  wire logic [NR-1:0]           chain_to_following_rule,
	input  wire logic [NR*PRD_W-1:0]     exec_period,
	input  wire logic [NR*2-1:0]         act_kind,
	input  wire logic [NR*4-1:0]         act_target,
	input  wire logic [NR-1:0]           act_polarity,
	input  wire logic [4*TMR_W-1:0]      timer_interval,
	input  wire logic [4*CNT_W-1:0]      counter_target,
	// results
	output logic      [15:0]             do_out,
	output logic      [15:0]             shared_internal_flag,
	output logic      [3:0][TMR_W-1:0]   timer_value,
	output logic      [3:0][CNT_W-1:0]   counter_value,
	output logic                         scan_done
);
	// ----------------------------------------------------------------
	// reset release
	// ----------------------------------------------------------------
	logic [1:0] rst_sync_reg;
	logic       rst_n;
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rst_sync_reg <= 2'b00;
		end else begin
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_reg[1];

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	rule_engine_pkg::phase_t        phase_reg;
	logic [3:0]                     idx_reg;
	logic [23:0]                    elapsed_reg;
	logic                           run_reg;
	logic [15:0]                    di_snap_reg;
	logic [NR-1:0]                  result_reg;
	logic [NR-1:0]                  fire_reg;
	logic [PRD_W-1:0]               period_cnt_reg [NR];
	logic [15:0]                    do_reg;
	logic [15:0]                    flag_reg;
	logic [3:0]                     timer_run_reg;
	logic [3:0][TMR_W-1:0]          timer_reg;
	logic [3:0][CNT_W-1:0]          counter_reg;
	logic [31:0]                    tick_cnt_reg;
	logic                           scan_done_reg;

	assign do_out               = do_reg;
	assign shared_internal_flag = flag_reg;
	assign timer_value          = timer_reg;
	assign counter_value        = counter_reg;
	assign scan_done            = scan_done_reg;

	// ----------------------------------------------------------------
	// condition evaluation of the current rule
	// ----------------------------------------------------------------
	logic [63:0] src;
	logic [3:0]  timer_done;
	logic [3:0]  counter_hit;
	logic        eval;
	logic        chain_in;
	logic        chained;
	logic        and_v;
	logic        or_v;
	logic        cbit;
	logic [5:0]  sel;
	logic [1:0]  op;
	logic [23:0] budget;

	always_comb begin
		for (int t = 0; t < 4; t++) begin
			timer_done[t]  = timer_reg[t] >= timer_interval[t*TMR_W +: TMR_W];             // [RULE14]
			counter_hit[t] = counter_reg[t] == counter_target[t*CNT_W +: CNT_W];
		end
		src = 64'h0000_0000_0000_0000;
		src[`LRE_SRC_DI +: 16]      = di_snap_reg;
		src[`LRE_SRC_FLAG +: 16]    = flag_reg;                                             // [RULE3] [RULE4] [RULE15]
		src[`LRE_SRC_TIMER +: 4]    = timer_done;
		src[`LRE_SRC_COUNTER +: 4]  = counter_hit;
		src[`LRE_SRC_EXT_FLAG +: 16] = ext_flag_in;                                         // [RULE11] [RULE7]
	end

	always_comb begin
		and_v = 1'b1;
		or_v  = 1'b0;
		for (int k = 0; k < `LRE_NUM_COND; k++) begin                                       // [RULE8]
			sel  = cond_sel[(idx_reg*3 + k)*6 +: 6];
			cbit = src[sel] ^ cond_expect_false[idx_reg*3 + k];                             // [RULE12]
			if (cond_used[idx_reg*3 + k]) begin
				and_v = and_v & cbit;
				or_v  = or_v | cbit;
			end
		end
		// only the rule directly before may chain in
		chained  = (idx_reg != 4'h0) && chain_to_following_rule[idx_reg - 4'h1]
			&& rule_enable[idx_reg - 4'h1];                                                  // [RULE10]
		chain_in = result_reg[idx_reg - 4'h1];
		if (chained) begin                                                                  // [RULE9]
			and_v = and_v & chain_in;
			or_v  = or_v | chain_in;
		end
		op = rule_op[idx_reg*2 +: 2];
		unique case (op)
			rule_engine_pkg::OP_AND:  eval = and_v;
			rule_engine_pkg::OP_OR:   eval = or_v;
			rule_engine_pkg::OP_NAND: eval = ~and_v;
			rule_engine_pkg::OP_NOR:  eval = ~or_v;
		endcase
	end

	// scan length grows with the number of enabled rules
	always_comb begin
		budget = BASE_CYCLES;
		for (int r = 0; r < NR; r++) begin
			if (rule_enable[r]) begin
				budget = budget + PER_CYCLES;                                               // [RULE5] [RULE6]
			end
		end
	end

	// ----------------------------------------------------------------
	// scan sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			phase_reg     <= rule_engine_pkg::PH_IDLE;
			idx_reg       <= 4'h0;
			elapsed_reg   <= 24'h00_0000;
			run_reg       <= 1'b0;
			di_snap_reg   <= 16'h0000;
			scan_done_reg <= 1'b0;
		end else begin
			run_reg       <= run;
			scan_done_reg <= 1'b0;
			elapsed_reg   <= elapsed_reg + 24'h00_0001;
			if (!run_reg) begin
				phase_reg <= rule_engine_pkg::PH_IDLE;
				idx_reg   <= 4'h0;
			end else begin
				unique case (phase_reg)
					rule_engine_pkg::PH_IDLE: begin
						phase_reg   <= rule_engine_pkg::PH_COND;
						elapsed_reg <= 24'h00_0000;
						di_snap_reg <= di;
					end
					rule_engine_pkg::PH_COND: begin                                         // [RULE2]
						idx_reg <= idx_reg + 4'h1;
						if (idx_reg == 4'hF) begin
							phase_reg <= rule_engine_pkg::PH_EXEC;
						end
					end
					rule_engine_pkg::PH_EXEC: begin                                         // [RULE2]
						idx_reg <= idx_reg + 4'h1;
						if (idx_reg == 4'hF) begin
							phase_reg <= rule_engine_pkg::PH_OUT;
						end
					end
					rule_engine_pkg::PH_OUT: begin                                          // [RULE2]
						idx_reg <= idx_reg + 4'h1;
						if (idx_reg == 4'hF) begin
							phase_reg <= rule_engine_pkg::PH_WAIT;
						end
					end
					rule_engine_pkg::PH_WAIT: begin                                         // [RULE5]
						if (elapsed_reg >= budget - 24'h00_0001) begin
							phase_reg     <= rule_engine_pkg::PH_COND;
							elapsed_reg   <= 24'h00_0000;
							di_snap_reg   <= di;
							scan_done_reg <= 1'b1;
						end
					end
					default: phase_reg <= rule_engine_pkg::PH_IDLE;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// condition results and execution period
	// ----------------------------------------------------------------
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			result_reg <= '0;
		end else if (phase_reg == rule_engine_pkg::PH_COND) begin
			result_reg[idx_reg] <= rule_enable[idx_reg] & eval;                             // [RULE1] [RULE19]
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			fire_reg <= '0;
			for (int r = 0; r < NR; r++) begin
				period_cnt_reg[r] <= '0;
			end
		end else if (!run_reg) begin
			fire_reg <= '0;
			for (int r = 0; r < NR; r++) begin
				period_cnt_reg[r] <= '0;
			end
		end else if (phase_reg == rule_engine_pkg::PH_EXEC) begin
			// period counts in scans; zero fires every scan
			if (!rule_enable[idx_reg]) begin
				fire_reg[idx_reg] <= 1'b0;                                                  // [RULE19]
			end else if (period_cnt_reg[idx_reg] >= exec_period[idx_reg*PRD_W +: PRD_W]) begin
				fire_reg[idx_reg]       <= 1'b1;                                            // [RULE13]
				period_cnt_reg[idx_reg] <= '0;
			end else begin
				fire_reg[idx_reg]       <= 1'b0;
				period_cnt_reg[idx_reg] <= period_cnt_reg[idx_reg] + 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// output phase actions
	// ----------------------------------------------------------------
	logic                            act_now;
	rule_engine_pkg::action_kind_t   kind;
	logic [3:0]                      tgt;
	logic                            res;
	logic                            pol;
	logic                            val;
	logic                            tick;
	assign act_now = (phase_reg == rule_engine_pkg::PH_OUT) && fire_reg[idx_reg];           // [RULE3]
	assign kind    = rule_engine_pkg::action_kind_t'(act_kind[idx_reg*2 +: 2]);
	assign tgt     = act_target[idx_reg*4 +: 4];
	assign res     = result_reg[idx_reg];
	assign pol     = act_polarity[idx_reg];
	assign val     = res ^ pol;
	assign tick    = tick_cnt_reg == 32'(TICK_CYCLES - 1);

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			do_reg   <= 16'h0000;
			flag_reg <= 16'h0000;
		end else if (!run_reg) begin
			do_reg   <= 16'h0000;
			flag_reg <= 16'h0000;                                                           // [RULE18]
		end else if (act_now && kind == rule_engine_pkg::ACT_DO) begin
			do_reg[tgt] <= val;
		end else if (act_now && kind == rule_engine_pkg::ACT_FLAG) begin
			flag_reg[tgt] <= val;                                                           // [RULE4] [RULE15]
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			tick_cnt_reg <= 32'h0000_0000;
		end else if (tick) begin
			tick_cnt_reg <= 32'h0000_0000;
		end else begin
			tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
		end
	end

	// timers count microseconds while running
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			timer_run_reg <= 4'h0;
			timer_reg     <= '0;
		end else if (!run_reg) begin
			timer_run_reg <= 4'h0;
			timer_reg     <= '0;                                                            // [RULE18]
		end else begin
			for (int t = 0; t < 4; t++) begin
				if (act_now && kind == rule_engine_pkg::ACT_TIMER && tgt[1:0] == 2'(t)) begin
					timer_run_reg[t] <= val;                                                // [RULE16]
					if (!val) begin
						timer_reg[t] <= '0;
					end
				end else if (timer_run_reg[t] && tick && timer_reg[t] != '1) begin
					timer_reg[t] <= timer_reg[t] + 1'b1;                                    // [RULE14]
				end
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			counter_reg <= '0;
		end else if (!run_reg) begin
			counter_reg <= '0;                                                              // [RULE18]
		end else if (act_now && kind == rule_engine_pkg::ACT_COUNTER && res) begin          // [RULE17]
			if (pol) begin
				counter_reg[tgt[1:0]] <= '0;
			end else begin
				counter_reg[tgt[1:0]] <= counter_reg[tgt[1:0]] + 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	logic [CNT_W-1:0] cnt_sel;
	assign cnt_sel = counter_reg[tgt[1:0]];

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	AST_FLAG_ONLY_IN_OUT: assert property ($changed(flag_reg) |->                                    // [RULE3]
		$past(phase_reg == rule_engine_pkg::PH_OUT) || $past(!run_reg))
		else $error("flag changed outside output phase");
	AST_DISABLED_NO_ACT: assert property (act_now |-> rule_enable[idx_reg])                           // [RULE19]
		else $error("disabled rule acted");
	AST_COND_TO_EXEC: assert property (run_reg && idx_reg == 4'hF                                    // [RULE2]
		&& phase_reg == rule_engine_pkg::PH_COND |=> phase_reg == rule_engine_pkg::PH_EXEC && idx_reg == 4'h0)
		else $error("bad phase order");
	AST_EXEC_TO_OUT: assert property (run_reg && idx_reg == 4'hF                                     // [RULE2]
		&& phase_reg == rule_engine_pkg::PH_EXEC |=> phase_reg == rule_engine_pkg::PH_OUT)
		else $error("exec not followed by output");
	AST_FLAG_WRITE: assert property (run_reg && act_now && kind == rule_engine_pkg::ACT_FLAG         // [RULE4]
		|=> flag_reg[$past(tgt)] == $past(val)) else $error("flag not written");
	AST_TIMER_CLEAR: assert property (run_reg && act_now && kind == rule_engine_pkg::ACT_TIMER       // [RULE16]
		&& !val |=> timer_reg[$past(tgt[1:0])] == '0 && !timer_run_reg[$past(tgt[1:0])])
		else $error("timer not cleared");
	AST_COUNTER_INC: assert property (run_reg && act_now && kind == rule_engine_pkg::ACT_COUNTER     // [RULE17]
		&& res && !pol |=> counter_reg[$past(tgt[1:0])] == $past(cnt_sel) + 1'b1)
		else $error("counter not incremented");
	AST_COUNTER_IDLE: assert property (run_reg && act_now && kind == rule_engine_pkg::ACT_COUNTER    // [RULE17]
		&& !res |=> $stable(counter_reg)) else $error("counter moved on unsatisfied rule");
	AST_WAIT_HOLDS: assert property (run_reg && run && phase_reg == rule_engine_pkg::PH_WAIT         // [RULE5]
		&& elapsed_reg < budget - 24'h00_0001 |=> phase_reg == rule_engine_pkg::PH_WAIT)
		else $error("scan ended early");
	AST_STOP_CLEARS: assert property (!run_reg |=>                                                   // [RULE18]
		flag_reg == 16'h0000 && counter_reg == '0 && timer_reg == '0)
		else $error("state not cleared when stopped");

	COV_CHAIN: cover property (phase_reg == rule_engine_pkg::PH_COND && chained && chain_in);
	COV_SCAN: cover property (scan_done_reg);
	COV_TIMER_DONE: cover property (timer_run_reg[0] && timer_done[0]);
	COV_COUNT: cover property (act_now && kind == rule_engine_pkg::ACT_COUNTER && res && !pol);

endmodule

// ---- tb/field_io_model.sv ----
/*
 * Field side of the rule engine: digital input levels and flags linked from other modules.
 * Assumes the bench calls apply() to move the levels; they change on the falling edge only.
 */
`timescale 1ns/1ps

module field_io_model (
	// clock
	input  wire logic        clock,
	// field levels seen by the engine
	output logic      [15:0] di,
	output logic      [15:0] ext_flag_in
);
	initial begin
		di = 16'h0000;
		ext_flag_in = 16'h0000;
	end

	// levels move off the sampling edge so the scan snapshot never races them
	task automatic apply(input logic [15:0] d, input logic [15:0] e);
		@(negedge clock);
		di <= d;
		ext_flag_in <= e;
	endtask
endmodule

// ---- tb/logic_rule_engine_tb.sv ----
/*
 * Self-checking bench of the rule engine: a scan-level model is compared at every scan end of the random and chaining tests.
 * Assumes the design files are compiled first and field_io_model drives the field inputs.
 */
`timescale 1ns/1ps

module logic_rule_engine_tb;
	localparam logic [23:0] BASE = 24'h00_0028;
	localparam logic [23:0] PER  = 24'h00_000a;

	logic              clock = 1'b0;
	logic              arst_n;
	logic              run;
	logic [15:0]       di;
	logic [15:0]       ext_flag_in;
	logic [15:0]       rule_enable;
	logic [287:0]      cond_sel;
	logic [47:0]       cond_used;
	logic [47:0]       cond_expect_false;
	logic [31:0]       rule_op;
	logic [15:0]       chain_to_following_rule;
	logic [127:0]      exec_period;
	logic [31:0]       act_kind;
	logic [63:0]       act_target;
	logic [15:0]       act_polarity;
	logic [63:0]       timer_interval;
	logic [63:0]       counter_target;
	logic [15:0]       do_out;
	logic [15:0]       shared_internal_flag;
	logic [3:0][15:0]  timer_value;
	logic [3:0][15:0]  counter_value;
	logic              scan_done;
	logic [15:0]       m_do;
	logic [15:0]       m_flag;
	logic [15:0]       snap_di;
	logic [15:0]       snap_ext;
	logic [15:0]       hist;
	logic [15:0]       m_cnt [4];
	logic [3:0]        m_ton;
	int                num_errors = 0;
	int                tests_run = 0;
	int                seed;
	int                cyc = 0;
	bit                have = 1'b0;

	always #4 clock = ~clock;

	field_io_model fio (.clock(clock), .di(di), .ext_flag_in(ext_flag_in));

	logic_rule_engine #(.BASE_CYCLES(BASE), .PER_CYCLES(PER), .TICK_CYCLES(4)) uut (
		.clock(clock), .arst_n(arst_n), .run(run), .di(di), .ext_flag_in(ext_flag_in),
		.rule_enable(rule_enable), .cond_sel(cond_sel), .cond_used(cond_used),
		.cond_expect_false(cond_expect_false), .rule_op(rule_op),
		.chain_to_following_rule(chain_to_following_rule), .exec_period(exec_period),
		.act_kind(act_kind), .act_target(act_target), .act_polarity(act_polarity),
		.timer_interval(timer_interval), .counter_target(counter_target), .do_out(do_out),
		.shared_internal_flag(shared_internal_flag), .timer_value(timer_value),
		.counter_value(counter_value), .scan_done(scan_done));

	// ----------------------------------------
	// checking and model
	// ----------------------------------------
	task automatic check(input logic [127:0] seen, input logic [127:0] exp);
		tests_run++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic results;
		$display("errors=%0d checks=%0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	function automatic logic src(input logic [5:0] s);
		if (s < 6'd16) return snap_di[s[3:0]];
		if (s < 6'd32) return m_flag[s[3:0]];
		if (s < 6'd36) return timer_interval[s[1:0]*16 +: 16] == 16'h0000;
		if (s < 6'd40) return m_cnt[s[1:0]] == counter_target[s[1:0]*16 +: 16];
		if (s < 6'd56) return snap_ext[4'(s - 6'd40)];
		return 1'b0;
	endfunction

	task automatic model_scan;
		logic [15:0] res;
		logic        all;
		logic        any;
		logic        v;
		logic [3:0]  t;
		res = 16'h0000;
		for (int r = 0; r < 16; r++) begin
			all = 1'b1;
			any = 1'b0;
			for (int k = 0; k < 3; k++) begin
				v = src(cond_sel[(r*3+k)*6 +: 6]) ^ cond_expect_false[r*3+k];
				if (cond_used[r*3+k]) begin
					all &= v;
					any |= v;
				end
			end
			if (r > 0 && chain_to_following_rule[r-1] && rule_enable[r-1]) begin
				all &= res[r-1];
				any |= res[r-1];
			end
			case (rule_op[r*2 +: 2])
				2'h0: res[r] = all;
				2'h1: res[r] = any;
				2'h2: res[r] = !all;
				default: res[r] = !any;
			endcase
			res[r] &= rule_enable[r];
		end
		for (int r = 0; r < 16; r++) if (rule_enable[r]) begin
			t = act_target[r*4 +: 4];
			v = res[r] ^ act_polarity[r];
			case (act_kind[r*2 +: 2])
				2'h0: m_do[t] = v;
				2'h1: m_flag[t] = v;
				2'h2: m_ton[t[1:0]] = v;
				default: if (res[r]) m_cnt[t[1:0]] = act_polarity[r] ? 16'h0000 : m_cnt[t[1:0]] + 16'h0001;
			endcase
		end
	endtask

	// ----------------------------------------
	// stimulus tasks
	// ----------------------------------------
	task automatic set_rule(input int r, input logic [17:0] sel, input logic [2:0] used, input logic [2:0] ef,
		input logic [1:0] op, input logic ch, input logic [1:0] kind, input logic [3:0] tgt, input logic pol,
		input logic en, input logic [7:0] prd);
		cond_sel[r*18 +: 18] = sel;
		cond_used[r*3 +: 3] = used;
		cond_expect_false[r*3 +: 3] = ef;
		rule_op[r*2 +: 2] = op;
		chain_to_following_rule[r] = ch;
		act_kind[r*2 +: 2] = kind;
		act_target[r*4 +: 4] = tgt;
		act_polarity[r] = pol;
		rule_enable[r] = en;
		exec_period[r*8 +: 8] = prd;
	endtask

	task automatic stop_run;
		@(negedge clock);
		run = 1'b0;
		repeat (4) @(negedge clock);
		check({do_out, shared_internal_flag, counter_value}, 128'h0);
		check(timer_value, 128'h0);
	endtask

	task automatic start_run;
		stop_run();
		m_do = 16'h0000;
		m_flag = 16'h0000;
		m_ton = 4'h0;
		for (int t = 0; t < 4; t++) m_cnt[t] = 16'h0000;
		snap_di = di;
		snap_ext = ext_flag_in;
		run = 1'b1;
	endtask

	task automatic wait_done;
		int k;
		k = 0;
		@(negedge clock);
		while (scan_done !== 1'b1 && k < 3000) begin
			@(negedge clock);
			k++;
		end
		if (k >= 3000) begin
			num_errors++;
			results();
		end
	endtask

	// mode 0 random levels, 1 near-all-ones on twelve inputs, 2 levels untouched
	task automatic scans(input int n, input bit use_model, input int mode);
		for (int i = 0; i < n; i++) begin
			wait_done();
			if (use_model) begin
				model_scan();
				check(do_out, m_do);
				check(shared_internal_flag, m_flag);
				for (int t = 0; t < 4; t++) begin
					check(counter_value[t], m_cnt[t]);
					check(timer_value[t] != 16'h0000, m_ton[t]);
				end
			end
			hist[i] = shared_internal_flag[0];
			snap_di = di;
			snap_ext = ext_flag_in;
			repeat (52) @(negedge clock);
			if (mode == 0) fio.apply(16'($random(seed)), 16'($random(seed)));
			if (mode == 1) fio.apply(16'h0fff & ~(16'(i % 2) << ($unsigned($random(seed)) % 12)), 16'h0000);
		end
	endtask

	// scan length follows the count of enabled rules
	always @(negedge clock) begin
		if (run !== 1'b1) begin
			have = 1'b0;
			cyc = 0;
		end else begin
			cyc = cyc + 1;
			if (scan_done === 1'b1) begin
				if (have) check(cyc, BASE + PER * $countones(rule_enable));
				have = 1'b1;
				cyc = 0;
			end
		end
	end

	initial begin
		#400_000;
		num_errors++;
		results();
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		seed = 32'h0000_6614;
		arst_n = 1'b0;
		run = 1'b0;
		timer_interval = {16'hffff, 16'hffff, 16'hffff, 16'h0000};
		counter_target = 64'h0;
		for (int r = 0; r < 16; r++) set_rule(r, 18'h0, 3'h0, 3'h0, 2'h0, 1'b0, 2'h0, 4'h0, 1'b0, 1'b0, 8'h00);
		repeat (12) @(negedge clock);
		arst_n = 1'b1;
		repeat (4) @(negedge clock);
		for (int c = 0; c < 3; c++) begin
			for (int r = 0; r < 16; r++)
				set_rule(r, 18'($random(seed)), 3'($random(seed)), 3'($random(seed)), 2'($random(seed)),
					1'($random(seed)), 2'($random(seed)), 4'($random(seed)), 1'($random(seed)),
					1'($random(seed)) | (r < 3), 8'h00);
			for (int t = 0; t < 4; t++) counter_target[t*16 +: 16] = 16'($unsigned($random(seed)) % 4);
			start_run();
			scans(8, 1'b1, 0);
		end
		// twelve inputs folded into one AND through adjacent chaining
		for (int r = 0; r < 16; r++) set_rule(r, 18'h0, 3'h0, 3'h0, 2'h0, 1'b0, 2'h0, 4'hf, 1'b0, 1'b0, 8'h00);
		for (int r = 0; r < 4; r++)
			set_rule(r, {6'(3*r+2), 6'(3*r+1), 6'(3*r)}, 3'h7, 3'h0, 2'h0, r < 3, 2'h0, 4'(r == 3 ? 0 : r + 4),
				1'b0, 1'b1, 8'h00);
		set_rule(5, 18'h0, 3'h0, 3'h0, 2'h0, 1'b0, 2'h0, 4'h9, 1'b0, 1'b1, 8'h00);
		start_run();
		scans(8, 1'b1, 1);
		// flag flicker by feedback, slowed by the execution period; an output follows the flag
		for (int r = 0; r < 6; r++) set_rule(r, 18'h0, 3'h0, 3'h0, 2'h0, 1'b0, 2'h0, 4'hf, 1'b0, 1'b0, 8'h00);
		set_rule(0, 18'd16, 3'h1, 3'h0, 2'h2, 1'b0, 2'h1, 4'h0, 1'b0, 1'b1, 8'h01);
		set_rule(1, 18'd16, 3'h1, 3'h0, 2'h1, 1'b0, 2'h0, 4'h0, 1'b0, 1'b1, 8'h00);
		start_run();
		scans(8, 1'b0, 2);
		for (int i = 0; i < 6; i++) check(hist[i+2], !hist[i]);
		check(hist[0] ^ hist[1] ^ hist[2] ^ hist[3], 1'b0);
		// the ninth scan has already run its output phase from the flag left by scan eight
		check(do_out[0], hist[7]);
		stop_run();
		results();
	end
endmodule
